// File: include/rcf_defs.svh
// rcf_defs.svh: offsets, field positions, reset values and rates for the
// resolver configuration and fault register group.
// assumes a single 125 MHz mclk and a nominal 8.192 MHz converter input clock.
//
// Functional notes
// - seven-bit frequency word sets excitation frequency
// - frequency equals word times clock over 2^15
// - power-up excitation is 10 kHz
// - control register resets to 0x7E
// - D5 picks 360 or +-44 degree lock
// - D4 enables hysteresis, enabled at power-up
// - hysteresis hides one-LSB position changes
// - D3/D2 pick 10/12/14/16 bit encoder
// - encoder resolution is 16 bits at power-up
// - config mode uses D1/D0, normal uses pins
// - output resolution is 12 bits at power-up
// - byte top bit marks address or data
// - data write stores parity in top bit
// - read returns top bit high on parity mismatch
// - address 0xF0 in config mode soft-resets
// - soft reset restarts loop, keeps config, clears faults
// - soft reset restarts excitation phase deterministically
// - fault register flags drive fault pins low
// - fault bit order clipped down to parity
// - sample fall after fault read clears faults
// - hysteresis zeroes unused position low bits
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH

`define RCF_ADDR_POS_HI     8'h80
`define RCF_ADDR_POS_LO     8'h81
`define RCF_ADDR_EXC_FREQ   8'h91
`define RCF_ADDR_CONTROL    8'h92
`define RCF_ADDR_SOFT_RST   8'hF0
`define RCF_ADDR_FAULT      8'hFF

`define RCF_BIT_ADDR_FLAG   7
`define RCF_RST_EXC_FREQ    8'h28
`define RCF_RST_CONTROL     8'h7E

`define RCF_MCLK_HZ         32'd125000000
`define RCF_REF_CLK_HZ      32'd8192000
`define RCF_PHASE_BITS      15

`define RCF_FLT_CLIPPED     7
`define RCF_FLT_SIG_ABSENT  6
`define RCF_FLT_OVERRANGE   5
`define RCF_FLT_MISMATCH    4
`define RCF_FLT_TRACK_ERR   3
`define RCF_FLT_OVERSPEED   2
`define RCF_FLT_PHASE_LOCK  1
`define RCF_FLT_CFG_PARITY  0

`endif

// File: include/rcf_pkg.sv
// rcf_pkg: types shared by the resolver configuration and fault registers.
// assumes rcf_defs.svh is available on the include path.
package rcf_pkg;

    // control register layout, top bit holds the stored parity
    typedef struct packed {
        logic       parity;
        logic       reserved;
        logic       phaseLockNarrow;
        logic       hystEnable;
        logic       encResHi;
        logic       encResLo;
        logic       outResHi;
        logic       outResLo;
    } rcf_ctrl_t;

    // host register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrStb;
        logic       rdStb;
    } rcf_bus_t;

endpackage

// File: core/rcf_config_fault_regs.sv
// rcf_config_fault_regs: excitation word, control, soft reset and sticky
// fault registers, with the excitation phase generator and position latch.
// assumes host strobes are synchronous to mclk and one cycle long; the analog
// fault detectors and the tracking loop sit outside and feed faultRaw/posInteg.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"

module rcf_config_fault_regs
    import rcf_pkg::*;
(
    input  wire logic            mclk,          // 125 MHz clock
    input  wire logic            rst,           // async reset, active high
    input  wire rcf_bus_t        bus,           // host register port
    input  wire logic            modeSelLo,     // mode select, low bit
    input  wire logic            modeSelHi,     // mode select, high bit
    input  wire logic            outResSelLo,   // resolution pin, low bit
    input  wire logic            outResSelHi,   // resolution pin, high bit
    input  wire logic            sampleN,       // sample strobe, falling edge acts
    input  wire logic [7:0]      faultRaw,      // live fault conditions
    input  wire logic [15:0]     posInteg,      // position integrator output
    output logic      [7:0]      rdData,        // read data, cycle after rdStb
    output logic                 excitation,    // excitation square output
    output logic                 trackRestart,  // one-cycle loop restart pulse
    output logic                 phaseLockWide, // 360 degree lock selected
    output logic                 hystOn,        // hysteresis enabled
    output logic      [1:0]      encResCode,    // 0:10 1:12 2:14 3:16 bits
    output logic      [1:0]      outResCode,    // same encoding
    output logic      [15:0]     position,      // latched position
    output logic                 signalDegradeN,// degradation fault pin
    output logic                 trackingLostN  // tracking fault pin
);

    localparam logic [31:0] REF_STEP = `RCF_REF_CLK_HZ;
    localparam logic [31:0] REF_WRAP = `RCF_MCLK_HZ;

    logic [7:0]  freqWord_q;
    rcf_ctrl_t   ctrl_q;
    logic [7:0]  pointer_q;
    logic [7:0]  fault_q;
    logic [7:0]  fault_d;
    logic        faultReadArm_q;
    logic        sampleN_q;
    logic [31:0] refAcc_q;
    logic [`RCF_PHASE_BITS-1:0] phase_q;
    logic        softRst_q;

    // access decode
    wire cfgMode     = modeSelHi & modeSelLo;
    wire isAddrByte  = bus.wrData[`RCF_BIT_ADDR_FLAG];
    wire wrAddr      = bus.wrStb & cfgMode & isAddrByte;
    wire wrDataByte  = bus.wrStb & cfgMode & ~isAddrByte;
    wire softRstHit  = wrAddr && bus.wrData == `RCF_ADDR_SOFT_RST;
    wire wrFreq      = wrDataByte && pointer_q == `RCF_ADDR_EXC_FREQ;
    wire wrCtrl      = wrDataByte && pointer_q == `RCF_ADDR_CONTROL;
    wire dataParity  = ^bus.wrData[6:0];
    wire [7:0] wrStore = {dataParity, bus.wrData[6:0]};

    // parity recheck of stored configuration
    wire freqParErr  = (^freqWord_q[6:0]) != freqWord_q[7];
    wire ctrlParErr  = (^ctrl_q[6:0]) != ctrl_q.parity;

    // sample edge and fault clearing
    wire sampleFall  = sampleN_q & ~sampleN;
    wire faultRead   = bus.rdStb & cfgMode && bus.addr == `RCF_ADDR_FAULT;
    wire faultClear  = (sampleFall & faultReadArm_q) | softRst_q;

    wire [7:0] faultSet = {faultRaw[7:1], faultRaw[0] | freqParErr | ctrlParErr};

    // set wins over clear; flags stay until cleared
    assign fault_d = (faultClear ? 8'h00 : fault_q) | faultSet;

    // resolution in force
    // code bit 0 is the high select bit, as in the encoder field
    wire [1:0] resCode  = cfgMode ? {ctrl_q.outResLo, ctrl_q.outResHi}
                                  : {outResSelLo, outResSelHi};
    wire [15:0] resMask = resCode == 2'h0 ? 16'hFFC0 :
                          resCode == 2'h1 ? 16'hFFF0 :
                          resCode == 2'h2 ? 16'hFFFC : 16'hFFFF;
    wire [15:0] resLsb  = ~resMask + 16'h0001;
    wire [15:0] posMasked = posInteg & resMask;
    wire [15:0] posDiff   = posMasked - position;
    wire        posSmall  = (posDiff == resLsb) || (posDiff == (16'h0000 - resLsb));
    wire        posHold   = ctrl_q.hystEnable & posSmall;
    wire [15:0] posNext   = ctrl_q.hystEnable ? posMasked : posInteg;

    // reference clock enable and excitation phase accumulator
    wire [31:0] refSum  = refAcc_q + REF_STEP;
    wire        refTick = refSum >= REF_WRAP;

    // read mux
    wire [7:0] rdSel =
        (bus.addr == `RCF_ADDR_EXC_FREQ && cfgMode) ? {freqParErr, freqWord_q[6:0]} :
        (bus.addr == `RCF_ADDR_CONTROL && cfgMode)  ? {ctrlParErr, ctrl_q[6:0]} :
        (bus.addr == `RCF_ADDR_FAULT && cfgMode)    ? fault_q :
        (bus.addr == `RCF_ADDR_POS_HI)              ? position[15:8] :
        (bus.addr == `RCF_ADDR_POS_LO)              ? position[7:0] : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            freqWord_q <= `RCF_RST_EXC_FREQ;
            ctrl_q     <= `RCF_RST_CONTROL;
            pointer_q  <= `RCF_ADDR_FAULT;
        end else begin
            if (wrAddr) begin
                pointer_q <= bus.wrData;
            end
            if (wrFreq) begin
                freqWord_q <= wrStore;
            end
            if (wrCtrl) begin
                ctrl_q <= wrStore;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_q        <= 8'h00;
            faultReadArm_q <= 1'b0;
            sampleN_q      <= 1'b1;
            softRst_q      <= 1'b0;
            signalDegradeN <= 1'b1;
            trackingLostN  <= 1'b1;
        end else begin
            fault_q        <= fault_d;
            sampleN_q      <= sampleN;
            softRst_q      <= softRstHit;
            faultReadArm_q <= faultRead | (faultReadArm_q & ~faultClear);
            signalDegradeN <= ~|fault_d[7:4];
            trackingLostN  <= ~|fault_d[3:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refAcc_q   <= 32'h0000_0000;
            phase_q    <= '0;
            excitation <= 1'b0;
        end else if (softRstHit) begin
            refAcc_q   <= 32'h0000_0000;
            phase_q    <= '0;
            excitation <= 1'b0;
        end else begin
            refAcc_q <= refTick ? refSum - REF_WRAP : refSum;
            if (refTick) begin
                phase_q <= phase_q + {8'h00, freqWord_q[6:0]};
            end
            excitation <= phase_q[`RCF_PHASE_BITS-1];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData        <= 8'h00;
            trackRestart  <= 1'b0;
            phaseLockWide <= 1'b0;
            hystOn        <= 1'b1;
            encResCode    <= 2'h3;
            outResCode    <= 2'h1;
            position      <= 16'h0000;
        end else begin
            rdData        <= bus.rdStb ? rdSel : 8'h00;
            trackRestart  <= softRstHit;
            phaseLockWide <= ~ctrl_q.phaseLockNarrow;
            hystOn        <= ctrl_q.hystEnable;
            encResCode    <= {ctrl_q.encResLo, ctrl_q.encResHi};
            outResCode    <= resCode;
            if (sampleFall && !posHold) begin
                position <= posNext;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_fault_read;
        faultRead;
    endsequence
    sequence s_sample_fall;
        sampleN_q && !sampleN;
    endsequence

    a_parity_store: assert property (wrFreq |=> freqWord_q[7] == ^freqWord_q[6:0])
        else $error("stored parity wrong after write");
    a_soft_reset_restart: assert property (softRstHit |=> trackRestart ##1 !trackRestart)
        else $error("restart pulse not one cycle");
    a_soft_reset_phase: assert property (softRstHit |=> phase_q == '0 && refAcc_q == 32'h0)
        else $error("excitation phase not restarted");
    a_config_kept: assert property (softRstHit |=> $stable(ctrl_q) && $stable(freqWord_q))
        else $error("configuration lost on soft reset");
    a_fault_clear_seq: assert property (faultReadArm_q ##0 s_sample_fall
        |=> fault_q == $past(faultSet))
        else $error("faults not cleared on sample fall");
    a_fault_sticky: assert property (fault_q[6] && !faultClear |=> fault_q[6])
        else $error("fault flag dropped");
    a_fault_pins: assert property (fault_q != 8'h00 && !faultClear && faultSet == fault_q
        |=> !(signalDegradeN && trackingLostN))
        else $error("fault pins not asserted");
    a_normal_no_write: assert property (bus.wrStb && !cfgMode |=> $stable(ctrl_q))
        else $error("write taken outside config mode");
    a_res_select: assert property (!cfgMode |=> outResCode == $past({outResSelLo, outResSelHi}))
        else $error("resolution not from pins in normal mode");
    a_read_parity: assert property (bus.rdStb && cfgMode && bus.addr == `RCF_ADDR_CONTROL
        |=> rdData[7] == $past(ctrlParErr))
        else $error("parity error bit wrong on read");
    a_pos_low_zero: assert property (sampleFall && !posHold && ctrl_q.hystEnable
        && resCode == 2'h1 |=> position[3:0] == 4'h0)
        else $error("unused position bits not zero");

    // register port: read data stands one cycle only
    sequence s_soft_hit;
        softRstHit;
    endsequence

    sequence s_restart_pulse;
        trackRestart ##1 !trackRestart;
    endsequence

    a_rd_idle_zero: assert property (!bus.rdStb |=> rdData == 8'h00)
        else $error("read data not idle");

    a_rd_freq_word: assert property (bus.rdStb && cfgMode && bus.addr == `RCF_ADDR_EXC_FREQ
        |=> rdData == $past({freqParErr, freqWord_q[6:0]}))
        else $error("frequency word read wrong");

    a_rd_fault_reg: assert property (bus.rdStb && cfgMode && bus.addr == `RCF_ADDR_FAULT
        |=> rdData == $past(fault_q))
        else $error("fault register read wrong");

    a_rd_pos_high: assert property (bus.rdStb && bus.addr == `RCF_ADDR_POS_HI
        |=> rdData == $past(position[15:8]))
        else $error("position high byte read wrong");

    a_rd_pos_low: assert property (bus.rdStb && bus.addr == `RCF_ADDR_POS_LO
        |=> rdData == $past(position[7:0]))
        else $error("position low byte read wrong");

    a_rd_cfg_hidden: assert property (bus.rdStb && !cfgMode &&
        (bus.addr == `RCF_ADDR_EXC_FREQ || bus.addr == `RCF_ADDR_CONTROL ||
         bus.addr == `RCF_ADDR_FAULT) |=> rdData == 8'h00)
        else $error("config register visible in normal mode");

    // configuration storage
    a_ctrl_store: assert property (wrCtrl |=> ctrl_q == $past(wrStore))
        else $error("control write not stored");

    a_ctrl_parity: assert property (wrCtrl |=> ctrl_q.parity == ^ctrl_q[6:0])
        else $error("control parity wrong after write");

    a_freq_store: assert property (wrFreq |=> freqWord_q == $past(wrStore))
        else $error("frequency write not stored");

    a_freq_hold: assert property (!wrFreq |=> $stable(freqWord_q))
        else $error("frequency word changed without write");

    a_ctrl_hold: assert property (!wrCtrl |=> $stable(ctrl_q))
        else $error("control changed without write");

    a_pointer_load: assert property (wrAddr |=> pointer_q == $past(bus.wrData))
        else $error("address byte not taken");

    a_pointer_hold: assert property (!wrAddr |=> $stable(pointer_q))
        else $error("pointer changed by data byte");

    a_normal_no_addr: assert property (bus.wrStb && !cfgMode |=> $stable(pointer_q))
        else $error("address taken outside config mode");

    // decoded control outputs
    a_lock_range: assert property (phaseLockWide == !$past(ctrl_q.phaseLockNarrow))
        else $error("lock range output wrong");

    a_hyst_out: assert property (hystOn == $past(ctrl_q.hystEnable))
        else $error("hysteresis output wrong");

    a_enc_twelve: assert property ($past(ctrl_q.encResHi) && !$past(ctrl_q.encResLo)
        |-> encResCode == 2'h1)
        else $error("encoder 12 bit code wrong");

    a_enc_fourteen: assert property (!$past(ctrl_q.encResHi) && $past(ctrl_q.encResLo)
        |-> encResCode == 2'h2)
        else $error("encoder 14 bit code wrong");

    a_out_twelve: assert property (cfgMode && ctrl_q.outResHi && !ctrl_q.outResLo
        |=> outResCode == 2'h1)
        else $error("output 12 bit code wrong");

    // soft reset and excitation generator
    a_restart_only_soft: assert property (!softRstHit |=> !trackRestart)
        else $error("restart pulse without soft reset");

    a_restart_seq: assert property (s_soft_hit |=> s_restart_pulse)
        else $error("restart sequence wrong");

    a_exc_soft_low: assert property (softRstHit |=> !excitation)
        else $error("excitation not restarted low");

    a_exc_follows: assert property (!softRstHit
        |=> excitation == $past(phase_q[`RCF_PHASE_BITS-1]))
        else $error("excitation not from phase top bit");

    a_phase_step: assert property (refTick && !softRstHit
        |=> phase_q == $past(phase_q) + $past({8'h00, freqWord_q[6:0]}))
        else $error("phase step wrong");

    a_phase_idle: assert property (!refTick && !softRstHit |=> $stable(phase_q))
        else $error("phase moved without reference tick");

    a_ref_below_wrap: assert property (refAcc_q < REF_WRAP)
        else $error("reference divider out of range");

    // fault flags and pins
    a_fault_arm: assert property (s_fault_read |=> faultReadArm_q)
        else $error("fault read did not arm clear");

    a_fault_set_wins: assert property (faultSet != 8'h00
        |=> (fault_q & $past(faultSet)) == $past(faultSet))
        else $error("fault event lost");

    a_fault_only_grow: assert property (!faultClear
        |=> (fault_q & $past(fault_q)) == $past(fault_q))
        else $error("fault flag cleared without clear");

    a_fault_soft_clear: assert property (softRst_q |=> fault_q == $past(faultSet))
        else $error("soft reset did not clear faults");

    a_pin_degrade: assert property (signalDegradeN == !(|fault_q[7:4]))
        else $error("degradation pin wrong");

    a_pin_lost: assert property (trackingLostN == !(|fault_q[3:0]))
        else $error("tracking pin wrong");

    // position latch
    a_pos_idle: assert property (!sampleFall |=> $stable(position))
        else $error("position moved without sample");

    a_pos_hyst_hold: assert property (sampleFall && posHold |=> $stable(position))
        else $error("one step change not suppressed");

    a_pos_raw: assert property (sampleFall && !ctrl_q.hystEnable
        |=> position == $past(posInteg))
        else $error("full position not latched");

endmodule

`default_nettype wire

// File: verif/rcf_host_model.sv
// rcf_host_model: host side of the register port, byte writes and reads.
// assumes the caller sets the mode select pins before register traffic.
`timescale 1ns/1ps
`default_nettype none
module rcf_host_model
    import rcf_pkg::*;
(
    input  wire logic       mclk,   // bench clock
    input  wire logic [7:0] rdData, // read data from the block
    output var  rcf_bus_t   bus     // register port towards the block
);
    initial bus = '{addr: 8'hFF, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b0};

    // top bit set marks an address byte, clear marks a data byte
    task automatic wr(input logic [7:0] b);
        @(posedge mclk);
        bus.wrStb  <= 1'b1;
        bus.wrData <= b;
        @(posedge mclk);
        bus.wrStb  <= 1'b0;
        bus.wrData <= ~b; // released lines never keep the old byte
    endtask

    task automatic wreg(input logic [7:0] a, input logic [6:0] d);
        wr(a);
        wr({1'b0, d});
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus.rdStb <= 1'b1;
        bus.addr  <= a;
        @(posedge mclk);
        bus.rdStb <= 1'b0;
        bus.addr  <= ~a;
        @(negedge mclk);
        d = rdData;
    endtask
endmodule
`default_nettype wire

// File: verif/rcf_config_fault_regs_tb.sv
// rcf_config_fault_regs_tb: random and corner checks of the configuration
// and fault registers through rcf_host_model.
// assumes 125 MHz mclk and the reference rate of rcf_defs.svh.
`timescale 1ns/1ps
`default_nettype none
module rcf_config_fault_regs_tb import rcf_pkg::*; ;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        modeSelHi = 1'b1;
    logic        sampleN = 1'b1;
    logic [7:0]  faultRaw = 8'h00;
    logic [15:0] posInteg = 16'h0000;
    logic [7:0]  rdData, r;
    logic [6:0]  d;
    logic [1:0]  encResCode, outResCode;
    logic [15:0] position;
    logic        excitation, trackRestart, phaseLockWide, hystOn, degN, lostN;
    rcf_bus_t    bus;
    int          failures = 0;
    int          check_count = 0;
    int          seed = 32'h3123;
    int          n, cnt;
    time         t0;

    always #4 mclk = ~mclk;

    rcf_config_fault_regs uut (.mclk(mclk), .rst(rst), .bus(bus), .modeSelLo(1'b1),
        .modeSelHi(modeSelHi), .outResSelLo(1'b0), .outResSelHi(1'b1), .sampleN(sampleN),
        .faultRaw(faultRaw), .posInteg(posInteg), .rdData(rdData), .excitation(excitation),
        .trackRestart(trackRestart), .phaseLockWide(phaseLockWide), .hystOn(hystOn),
        .encResCode(encResCode), .outResCode(outResCode), .position(position),
        .signalDegradeN(degN), .trackingLostN(lostN));
    rcf_host_model host (.mclk(mclk), .rdData(rdData), .bus(bus));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // mclk cycles per excitation period is 125e6 * 2^15 / (word * 8.192e6)
    function automatic logic [15:0] inrange(int g, int w);
        return (g * 100 > (500000 / w) * 99 && g * 100 < (500000 / w) * 101) ? 16'h1 : 16'h0;
    endfunction

    function automatic logic [15:0] ctl(logic [6:0] v);
        return {10'h0, v[2], v[3], v[0], v[1], v[4], ~v[5]};
    endfunction

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, r);
        check("rdData", {8'h00, r}, {8'h00, e});
    endtask

    task automatic ctlchk(input logic [6:0] v);
        check("ctl outputs", {10'h0, encResCode, outResCode, hystOn, phaseLockWide}, ctl(v));
    endtask

    task automatic pulse();
        @(posedge mclk) sampleN <= 1'b0;
        repeat (2) @(posedge mclk);
        sampleN <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    task automatic edge_gap(output int g);
        t0 = $time;
        @(posedge excitation);
        g = int'(($time - t0) / 8);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        ctlchk(7'h7E);
        rdc(8'h92, 8'h7E);
        rdc(8'h91, 8'h28);
        @(posedge excitation);
        edge_gap(n);
        check("period", inrange(n, 40), 16'h1);
        repeat (8) begin
            d = 7'($random(seed));
            host.wreg(8'h92, d);
            rdc(8'h92, {1'b0, d});
            ctlchk(d);
            d = 7'(7'h04 + $unsigned($random(seed)) % 77);
            host.wreg(8'h91, d);
            rdc(8'h91, {1'b0, d});
        end
        host.wreg(8'h92, 7'h7E);
        @(posedge mclk) modeSelHi <= 1'b0;
        host.wreg(8'h92, 7'h01);
        repeat (2) @(posedge mclk);
        check("normal res", {14'h0, outResCode}, 16'h1);
        @(posedge mclk) modeSelHi <= 1'b1;
        rdc(8'h92, 8'h7E);
        rdc(8'hA5, 8'h00);
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk) faultRaw <= 8'h01 << k;
            @(posedge mclk) faultRaw <= 8'h00;
            repeat (3) @(posedge mclk);
            check("fault pins", {14'h0, degN, lostN}, (k > 3) ? 16'h1 : 16'h2);
            rdc(8'hFF, 8'h01 << k);
            pulse();
            rdc(8'hFF, 8'h00);
        end
        check("fault pins", {14'h0, degN, lostN}, 16'h3);
        host.wreg(8'h92, 7'h5E);
        @(posedge mclk) faultRaw <= 8'h40;
        @(posedge mclk) faultRaw <= 8'h00;
        ctlchk(7'h5E);
        host.wreg(8'h91, 7'h50);
        cnt = 0;
        t0 = $time;
        fork
            host.wr(8'hF0);
            repeat (6) @(negedge mclk) cnt += int'(trackRestart);
        join
        @(posedge excitation);
        n = int'(($time - t0) / 8);
        check("restart phase", inrange(2 * n, 80), 16'h1);
        check("restart pulses", 16'(cnt), 16'h1);
        rdc(8'hFF, 8'h00);
        rdc(8'h91, 8'h50);
        edge_gap(n);
        check("period", inrange(n, 80), 16'h1);
        @(posedge mclk) posInteg <= {~position[15], 15'($random(seed))};
        pulse();
        check("position", position, posInteg & 16'hFFF0);
        @(posedge mclk) posInteg <= position + 16'h0010;
        pulse();
        check("position hold", position, posInteg - 16'h0010);
        host.wreg(8'h92, 7'h6E);
        @(posedge mclk) posInteg <= {~position[15], 15'($random(seed))};
        pulse();
        check("position", position, posInteg);
        close_out();
    end

    initial begin
        #(90000 * 8);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
